// >>> shared/eac_pkg.sv
// package: register map, fields and timing of the eeprom access control
package eac_pkg;
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned OSC_MHZ        = 1;
  localparam int unsigned WRITE_OSC_CYC  = 8448;
  localparam int unsigned OSC_DIV        = CLK_MHZ / OSC_MHZ;
  localparam int unsigned ARM_CYC        = 4;
  localparam int unsigned WSTALL_CYC     = 2;
  localparam int unsigned RSTALL_CYC     = 4;
  localparam int unsigned ADDR_W         = 9;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned DEPTH          = 512;
  localparam logic [1:0] SEL_DATA        = 2'h0;
  localparam logic [1:0] SEL_CTRL        = 2'h1;
  localparam logic [1:0] SEL_ADDR        = 2'h2;
  localparam int unsigned BIT_RDY_IE     = 3;
  localparam int unsigned BIT_ARM        = 2;
  localparam int unsigned BIT_WSTB       = 1;
  localparam int unsigned BIT_RSTB       = 0;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
endpackage

// >>> shared/eac_if.sv
// interface: register port between processor-side host and eeprom device
`timescale 1ns/1ns
interface eac_if;
  import eac_pkg::*;
  logic        wr_en;
  logic        rd_en;
  logic [1:0]  sel;
  logic [8:0]  wdata;
  logic [8:0]  rdata;
  logic        stall;
  logic        ready_irq;
  modport device (input wr_en, rd_en, sel, wdata, output rdata, stall, ready_irq);
  modport host   (output wr_en, rd_en, sel, wdata, input rdata, stall, ready_irq);
endinterface

// >>> core/eac_device.sv
// module: eeprom access control, device end with storage and write timer
`timescale 1ns/1ns
module eac_device
  import eac_pkg::*;
#(
  parameter int unsigned WRITE_CYC = WRITE_OSC_CYC * OSC_DIV
) (
  input  wire logic mclk,
  input  wire logic arst_n,
  eac_if.device     bus,
  input  wire logic global_irq_en,
  output logic      write_busy
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0]  data;
    logic [8:0]  addr;
    logic        rdy_ie;
    logic        arm;
    logic [2:0]  arm_cnt;
    logic        wstb;
    logic [23:0] wcnt;
    logic [2:0]  stall_cnt;
    logic        stall;
    logic [8:0]  rdata;
    logic        irq;
    logic        wr_go;
  } eac_dev_st_t;

  eac_dev_st_t st_q;
  eac_dev_st_t st_d;
  logic [7:0]  mem [DEPTH];
  logic [7:0]  ctrl_rd;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_d = st_q;
    st_d.wr_go = 1'b0;
    if (st_q.stall_cnt != 3'h0) begin
      st_d.stall_cnt = st_q.stall_cnt - 3'h1;
    end
    if (st_q.arm) begin
      if (st_q.arm_cnt == 3'(ARM_CYC - 1)) begin
        st_d.arm = 1'b0;
      end else begin
        st_d.arm_cnt = st_q.arm_cnt + 3'h1;
      end
    end
    if (st_q.wstb) begin
      // single-clock counter, stands for the 1 MHz oscillator count
      if (st_q.wcnt == 24'(WRITE_CYC - 1)) begin
        st_d.wstb = 1'b0;
        st_d.wr_go = 1'b1;
      end else begin
        st_d.wcnt = st_q.wcnt + 24'h1;
      end
    end
    if (bus.wr_en) begin
      case (bus.sel)
        SEL_DATA: st_d.data = bus.wdata[7:0];
        SEL_ADDR: begin
          if (!st_q.wstb) begin
            st_d.addr = bus.wdata[8:0];
          end
        end
        SEL_CTRL: begin
          st_d.rdy_ie = bus.wdata[BIT_RDY_IE];
          if (bus.wdata[BIT_ARM] && !bus.wdata[BIT_WSTB]) begin
            st_d.arm = 1'b1;
            st_d.arm_cnt = 3'h0;
          end
          if (bus.wdata[BIT_WSTB] && st_q.arm && !st_q.wstb) begin
            st_d.wstb = 1'b1;
            st_d.wcnt = 24'h0;
            st_d.arm = 1'b0;
            st_d.stall_cnt = 3'(WSTALL_CYC);
          end
          if (bus.wdata[BIT_RSTB] && !st_q.wstb) begin
            st_d.data = mem[st_q.addr];
            st_d.stall_cnt = 3'(RSTALL_CYC);
          end
        end
        default: st_d.data = st_q.data;
      endcase
    end
    case (bus.sel)
      SEL_DATA: st_d.rdata = {1'b0, st_d.data};
      SEL_CTRL: st_d.rdata = {1'b0, ctrl_rd};
      SEL_ADDR: st_d.rdata = st_d.addr;
      default:  st_d.rdata = 9'h000;
    endcase
    st_d.irq = st_d.rdy_ie && global_irq_en && !st_d.wstb;
    // stall registered so the core sees a clean level, not a compare
    st_d.stall = st_d.stall_cnt != 3'h0;
  end

  // reserved bits fixed at zero
  assign ctrl_rd = {4'h0, st_d.rdy_ie, st_d.arm, st_d.wstb, 1'b0};

  // ****************************************
  // registers
  // ****************************************
  // arst_n covers registers only; a real part keeps the timer on its own
  // always-on reset so a core reset cannot abort a write
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (st_q.wr_go) begin
      mem[st_q.addr] <= st_q.data;
    end
  end

  assign bus.rdata     = st_q.rdata;
  assign bus.stall     = st_q.stall;
  assign bus.ready_irq = st_q.irq;
  assign write_busy    = st_q.wstb;
endmodule

// >>> core/eac_host.sv
// module: eeprom access control, host end running the write and read sequences
`timescale 1ns/1ns
module eac_host
  import eac_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       arst_n,
  eac_if.host             bus,
  input  wire logic       req_wr,
  input  wire logic       req_rd,
  input  wire logic [8:0] req_addr,
  input  wire logic [7:0] req_data,
  input  wire logic       self_program_busy,
  output logic            done,
  output logic [7:0]      rd_data,
  output logic            busy
);
  // ****************************************
  // state
  // ****************************************
  typedef enum logic [3:0] {
    H_IDLE = 4'h0, H_POLL = 4'h1, H_ADDR = 4'h2, H_DATA = 4'h3,
    H_ARM  = 4'h4, H_STB  = 4'h5, H_RSTB = 4'h6, H_RGET = 4'h7,
    H_WAIT = 4'h8, H_DONE = 4'h9
  } eac_hst_e_t;

  typedef struct packed {
    eac_hst_e_t  fsm;
    logic        is_wr;
    logic [8:0]  addr;
    logic [7:0]  data;
    logic        wr_en;
    logic [1:0]  sel;
    logic [8:0]  wdata;
    logic        done;
    logic [7:0]  rd_data;
    logic        busy;
  } eac_hst_st_t;

  eac_hst_st_t st_q;
  eac_hst_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.wr_en = 1'b0;
    st_d.done = 1'b0;
    case (st_q.fsm)
      H_IDLE: begin
        if (req_wr || req_rd) begin
          st_d.is_wr = req_wr;
          st_d.addr = req_addr;
          st_d.data = req_data;
          st_d.sel = SEL_CTRL;
          st_d.fsm = H_POLL;
        end
      end
      H_POLL: begin
        // poll strobe, and self-programming for writes
        if (!bus.rdata[BIT_WSTB] && !bus.stall && !(st_q.is_wr && self_program_busy)) begin
          st_d.wr_en = 1'b1;
          st_d.sel = SEL_ADDR;
          st_d.wdata = st_q.addr;
          st_d.fsm = st_q.is_wr ? H_DATA : H_RSTB;
        end
      end
      H_DATA: begin
        st_d.wr_en = 1'b1;
        st_d.sel = SEL_DATA;
        st_d.wdata = {1'b0, st_q.data};
        st_d.fsm = H_ARM;
      end
      H_ARM: begin
        // no interrupts taken here, arm to strobe is back to back
        st_d.wr_en = 1'b1;
        st_d.sel = SEL_CTRL;
        st_d.wdata = 9'h004;
        st_d.fsm = H_STB;
      end
      H_STB: begin
        st_d.wr_en = 1'b1;
        st_d.wdata = 9'h002;
        st_d.fsm = H_WAIT;
      end
      H_RSTB: begin
        st_d.wr_en = 1'b1;
        st_d.sel = SEL_CTRL;
        st_d.wdata = 9'h001;
        st_d.fsm = H_RGET;
      end
      H_RGET: begin
        st_d.sel = SEL_DATA;
        st_d.fsm = H_WAIT;
      end
      H_WAIT: begin
        if (!bus.stall && !st_q.wr_en) begin
          st_d.rd_data = st_q.is_wr ? st_q.rd_data : bus.rdata[7:0];
          st_d.fsm = H_DONE;
        end
      end
      H_DONE: begin
        st_d.done = 1'b1;
        st_d.sel = SEL_CTRL;
        st_d.fsm = H_IDLE;
      end
      default: st_d.fsm = H_IDLE;
    endcase
    // busy from a flop, so it never glitches while the state decodes
    st_d.busy = st_d.fsm != H_IDLE;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign bus.wr_en = st_q.wr_en;
  assign bus.rd_en = 1'b0;
  assign bus.sel   = st_q.sel;
  assign bus.wdata = st_q.wdata;
  assign done      = st_q.done;
  assign rd_data   = st_q.rd_data;
  assign busy      = st_q.busy;
endmodule

// >>> tb/eac_chk.sv
// checker: port timing and readback relations of the eeprom access control
`timescale 1ns/1ns
module eac_chk
  import eac_pkg::*;
#(
  parameter int unsigned WRITE_CYC = WRITE_OSC_CYC * OSC_DIV
) (
  input wire logic       mclk,
  input wire logic       arst_n,
  input wire logic       wr_en,
  input wire logic [1:0] sel,
  input wire logic [8:0] wdata,
  input wire logic [8:0] rdata,
  input wire logic       stall,
  input wire logic       ready_irq,
  input wire logic       global_irq_en,
  input wire logic       write_busy
);
  // ****
  // assertions
  // ****
  logic        ctl;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  assign ctl = wr_en && sel == SEL_CTRL;
  // counter, since the write time is far beyond a repetition count
  always_comb cnt_d = write_busy ? cnt_q + 32'h1 : 32'h0;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) cnt_q <= 32'h0;
    else cnt_q <= cnt_d;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_busy_length: assert property ($fell(write_busy) |-> cnt_q == WRITE_CYC)
    else $error("write time wrong");
  a_strobe_cause: assert property ($rose(write_busy) |->
    $past(ctl) && $past(wdata[BIT_WSTB])) else $error("write start without strobe");
  a_write_stall: assert property ($rose(write_busy) |-> stall [*2] ##1 !stall)
    else $error("write stall length wrong");
  a_read_stall: assert property (ctl && wdata[BIT_RSTB] && !wdata[BIT_WSTB] && !write_busy
    |=> stall [*4] ##1 !stall) else $error("read stall length wrong");
  a_rsvd_zero: assert property (sel == SEL_CTRL |=> rdata[8:4] == 5'h00)
    else $error("reserved control bits not zero");
  a_strobe_rb: assert property (sel == SEL_CTRL |=> rdata[BIT_WSTB] == write_busy)
    else $error("strobe readback differs from write busy");
  a_arm_expire: assert property (ctl && wdata[BIT_ARM] && !wdata[BIT_WSTB]
    ##1 sel == SEL_CTRL [*4] |=> !rdata[BIT_ARM]) else $error("arm did not expire");
  a_irq_busy: assert property (write_busy && $past(write_busy) |-> !ready_irq)
    else $error("ready request during write");
  a_irq_global: assert property (!global_irq_en |=> !ready_irq)
    else $error("ready request with global disable");
  cover property ($fell(write_busy));
  cover property ($fell(stall) && !write_busy);
  cover property (ctl && wdata[BIT_ARM]);
endmodule

// >>> tb/eeprom_access_control_tb_top.sv
// testbench: host and device ends joined, corner and random byte traffic
`timescale 1ns/1ns
module eeprom_access_control_tb_top;
  import eac_pkg::*;
  // ****
  // bench
  // ****
  localparam int unsigned WCYC = 50;
  logic       mclk = 1'b0;
  logic       arst_n = 1'b0;
  logic       gie = 1'b0;
  logic       spb = 1'b0;
  logic       req_wr = 1'b0;
  logic       req_rd = 1'b0;
  logic [8:0] req_addr = 9'h000;
  logic [7:0] req_data = 8'h00;
  logic       done;
  logic       busy;
  logic       wbusy;
  logic [7:0] rd_data;
  logic [8:0] a;
  logic [7:0] shadow [DEPTH];
  int         fails = 0;
  int         cmp_count = 0;
  always #2 mclk = ~mclk;
  eac_if bus ();
  eac_device #(.WRITE_CYC(WCYC)) u_eac_device (.mclk(mclk), .arst_n(arst_n), .bus(bus),
    .global_irq_en(gie), .write_busy(wbusy));
  eac_host u_eac_host (.mclk(mclk), .arst_n(arst_n), .bus(bus), .req_wr(req_wr),
    .req_rd(req_rd), .req_addr(req_addr), .req_data(req_data), .self_program_busy(spb),
    .done(done), .rd_data(rd_data), .busy(busy));
  eac_chk #(.WRITE_CYC(WCYC)) u_eac_chk (.mclk(mclk), .arst_n(arst_n), .wr_en(bus.wr_en),
    .sel(bus.sel), .wdata(bus.wdata), .rdata(bus.rdata), .stall(bus.stall),
    .ready_irq(bus.ready_irq), .global_irq_en(gie), .write_busy(wbusy));
  function automatic logic [8:0] exp_byte(input logic [8:0] ad);
    return {1'b0, shadow[ad]};
  endfunction
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // request held one edge only, so the idle host cannot take it twice
  task automatic op(input logic wr, input logic [8:0] ad, input logic [7:0] d);
    int n;
    req_wr = wr;
    req_rd = !wr;
    req_addr = ad;
    req_data = d;
    @(posedge mclk);
    #1;
    req_wr = 1'b0;
    req_rd = 1'b0;
    for (n = 0; n < 400 && done !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    if (n == 400) begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [8:0] ad, input logic [7:0] d);
    op(1'b1, ad, d);
    shadow[ad] = d;
  endtask
  task automatic rd(input logic [8:0] ad);
    op(1'b0, ad, 8'h00);
    check("rd_data", {1'b0, rd_data}, exp_byte(ad));
    check("ready_irq", {8'h00, bus.ready_irq}, 9'h000);
  endtask
  initial begin
    void'($urandom(32'h6293));
    repeat (6) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    wr(9'h000, 8'hFF);
    wr(9'h1FF, 8'h00);
    wr(9'h1FF, 8'hA5);
    rd(9'h000);
    rd(9'h1FF);
    $display("test corners done");
    for (int i = 0; i < 8; i++) begin
      a = 9'($urandom());
      gie = 1'($urandom());
      wr(a, 8'($urandom()));
      rd(a);
    end
    $display("test random done");
    spb = 1'b1;
    fork
      wr(9'h055, 8'h3C);
      begin
        repeat (30) @(posedge mclk);
        #1;
        check("write_busy", {8'h00, wbusy}, 9'h000);
        check("busy", {8'h00, busy}, 9'h001);
        spb = 1'b0;
      end
    join
    rd(9'h055);
    $display("test hold-off done");
    tally_and_finish();
  end
endmodule
